// File: common/sensor_irq_defines.svh
`ifndef SENSOR_IRQ_DEFINES_SVH
`define SENSOR_IRQ_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_SYNC_FLAGS 8'h36
`define ADDR_PIN_CONFIG 8'h37
`define ADDR_IRQ_ENABLE 8'h38
`define ADDR_IRQ_FLAGS 8'h3A
`define ADDR_TEMP_HIGH 8'h41
`define ADDR_TEMP_LOW 8'h42
`define ADDR_RATE_X_HIGH 8'h43
`define ADDR_RATE_X_LOW 8'h44
`define ADDR_RATE_Y_HIGH 8'h45
`define ADDR_RATE_Y_LOW 8'h46
`define ADDR_RATE_Z_HIGH 8'h47
`define ADDR_RATE_Z_LOW 8'h48

// ****************************************************************
// Field positions
// ****************************************************************
`define PIN_POLARITY_BIT 7
`define PIN_OPEN_DRAIN_BIT 6
`define PIN_LATCH_BIT 5
`define PIN_ANY_READ_CLR_BIT 4
`define SYNC_POLARITY_BIT 3
`define SYNC_IRQ_EN_BIT 2
`define OVERFLOW_BIT 4
`define DRIVE_READY_BIT 2
`define SAMPLE_READY_BIT 0
`define SYNC_FLAG_BIT 7

// Writable bits and reset values
`define PIN_CONFIG_MASK 8'hFC
`define IRQ_ENABLE_MASK 8'h15
`define PIN_CONFIG_RESET 8'h00
`define IRQ_ENABLE_RESET 8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define SYS_CLK_MHZ 100
`define IRQ_PULSE_US 50

`endif

// File: common/sensor_irq_pkg.sv
package sensor_irq_pkg;

    // Interrupt pin pulse timer states
    typedef enum logic [0:0] {PIN_IDLE, PIN_PULSE} pulse_state_t;

    // Full-scale range codes
    typedef enum logic [1:0] {RANGE_250, RANGE_500, RANGE_1000, RANGE_2000} range_t;

endpackage : sensor_irq_pkg

// File: core/bit_sync.sv
// Two-stage synchroniser for an asynchronous pin
module bit_sync
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Pin and synchronised level
    input wire logic async_in,
    output logic sync_out
);

    logic meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            meta_r <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : bit_sync

// File: core/rate_scale.sv
// Scales a full-precision rate sample to the selected range
module rate_scale
    import sensor_irq_pkg::*;
(
    // Raw rate, 131 LSB per dps
    input wire logic signed [18:0] raw_rate,
    input wire range_t range_sel,
    // Saturated 16-bit rate word
    output logic [15:0] rate_word
);

    logic signed [18:0] shifted;

    // Each range step halves the sensitivity; clip to 16 bits
    always_comb
    begin
        shifted = raw_rate >>> range_sel;
        if (shifted > 19'sh07FFF)
            rate_word = 16'h7FFF;
        else if (shifted < -19'sh08000)
            rate_word = 16'h8000;
        else
            rate_word = shifted[15:0];
    end

endmodule : rate_scale

// File: core/sensor_irq_and_output_regs.sv
// Notes on behaviour
// - Pin polarity bit 1 makes interrupt pin active low, 0 active high.
// - Drive-type bit 1 makes pin open drain, 0 push-pull.
// - Latch bit 1 holds pin until status cleared; 0 gives 50 us pulse.
// - Any-read-clear bit 1: any read clears status; 0: flag register read only.
// - Sync polarity bit 1 treats frame sync as active low, 0 active high.
// - Sync enable raises interrupt on frame sync transition to active level.
// - Overflow event interrupts only while overflow enable bit is 1.
// - Drive-ready enable bit gates drive-ready interrupt.
// - Sample-ready enable bit gates data-ready interrupt.
// - Overflow flag sets on FIFO overflow, clears after flag register read.
// - Sample-ready flag sets on data ready, clears after flag register read.
// - Drive-ready event reported in its own bit of flag register.
// - Temperature word read-only, high byte 65, low byte 66.
// - X rate word read-only, high byte 67, low byte 68.
// - Y rate word read-only, high byte 69, low byte 70.
// - Z rate word read-only, high byte 71, low byte 72.
// - Rate word is sensitivity times rate, 131 LSB/dps at smallest range.
// - Range select 00..11 picks 250, 500, 1000, 2000 dps scaling.
// - Sync flag sets on frame sync interrupt, clears when its register read.

`include "sensor_irq_defines.svh"

module sensor_irq_and_output_regs
    import sensor_irq_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = `IRQ_PULSE_US * `SYS_CLK_MHZ
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port from the serial front end
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Sensor events, one-cycle pulses
    input wire logic fifo_overflow_evt,
    input wire logic drive_ready_evt,
    input wire logic sample_strobe,
    // Sensor samples, taken on sample_strobe
    input wire logic [15:0] temp_sample,
    input wire logic signed [18:0] raw_rate_x,
    input wire logic signed [18:0] raw_rate_y,
    input wire logic signed [18:0] raw_rate_z,
    input wire logic [1:0] range_select,
    // Frame sync pin
    input wire logic frame_sync_in,
    // Interrupt pin
    output logic irq_pin_o,
    output logic irq_pin_oe
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam logic [12:0] PULSE_LAST = 13'(PULSE_CYCLES - 1);

    logic [7:0] pin_config_r;
    logic [7:0] irq_enable_r;
    logic overflow_flag_r;
    logic drive_ready_flag_r;
    logic sample_ready_flag_r;
    logic sync_in_flag_r;
    logic [15:0] temp_word_r;
    logic [15:0] rate_x_word_r;
    logic [15:0] rate_y_word_r;
    logic [15:0] rate_z_word_r;
    logic [15:0] rate_x_scaled;
    logic [15:0] rate_y_scaled;
    logic [15:0] rate_z_scaled;
    logic sync_level;
    logic sync_prev_r;
    logic sync_edge;
    logic clear_status;
    logic clear_sync;
    logic irq_event;
    logic irq_pending;
    logic irq_active;
    logic [7:0] read_mux;
    logic [12:0] pulse_cnt_r;
    pulse_state_t pulse_state_r;

    // Configuration fields
    logic pin_active_low;
    logic pin_open_drain;
    logic pin_latched;
    logic any_read_clears;
    logic sync_in_polarity;
    logic sync_in_irq_enable;
    logic overflow_irq_enable;
    logic drive_ready_irq_enable;
    logic sample_ready_irq_enable;

    assign pin_active_low = pin_config_r[`PIN_POLARITY_BIT];
    assign pin_open_drain = pin_config_r[`PIN_OPEN_DRAIN_BIT];
    assign pin_latched = pin_config_r[`PIN_LATCH_BIT];
    assign any_read_clears = pin_config_r[`PIN_ANY_READ_CLR_BIT];
    assign sync_in_polarity = pin_config_r[`SYNC_POLARITY_BIT];
    assign sync_in_irq_enable = pin_config_r[`SYNC_IRQ_EN_BIT];
    assign overflow_irq_enable = irq_enable_r[`OVERFLOW_BIT];
    assign drive_ready_irq_enable = irq_enable_r[`DRIVE_READY_BIT];
    assign sample_ready_irq_enable = irq_enable_r[`SAMPLE_READY_BIT];

    // ****************************************************************
    // Configuration registers
    // ****************************************************************

    // Bits 1 and 0 of the pin config are not stored and read as zero
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            pin_config_r <= `PIN_CONFIG_RESET;
            irq_enable_r <= `IRQ_ENABLE_RESET;
        end
        else if (reg_wr_en)
        begin
            if (reg_addr == `ADDR_PIN_CONFIG)
                pin_config_r <= reg_wdata & `PIN_CONFIG_MASK;
            if (reg_addr == `ADDR_IRQ_ENABLE)
                irq_enable_r <= reg_wdata & `IRQ_ENABLE_MASK;
        end
    end

    // ****************************************************************
    // Frame sync edge detect
    // ****************************************************************

    // Pin is asynchronous to sys_clk
    bit_sync u_sync_frame_sync_in
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .async_in(frame_sync_in),
        .sync_out(sync_level)
    );

    // Raw level history keeps a polarity change from faking an edge
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            sync_prev_r <= 1'b0;
        else
            sync_prev_r <= sync_level;
    end

    assign sync_edge = sync_in_irq_enable
        && ((sync_level ^ sync_in_polarity) && !(sync_prev_r ^ sync_in_polarity));

    // ****************************************************************
    // Status flags
    // ****************************************************************

    assign clear_status = reg_rd_en
        && (any_read_clears || (reg_addr == `ADDR_IRQ_FLAGS));
    assign clear_sync = reg_rd_en
        && (any_read_clears || (reg_addr == `ADDR_SYNC_FLAGS));

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            overflow_flag_r <= 1'b0;
        else if (fifo_overflow_evt)
            overflow_flag_r <= 1'b1;
        else if (clear_status)
            overflow_flag_r <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            drive_ready_flag_r <= 1'b0;
        else if (drive_ready_evt)
            drive_ready_flag_r <= 1'b1;
        else if (clear_status)
            drive_ready_flag_r <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            sample_ready_flag_r <= 1'b0;
        else if (sample_strobe)
            sample_ready_flag_r <= 1'b1;
        else if (clear_status)
            sample_ready_flag_r <= 1'b0;
    end

    // sync flag in its own register
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            sync_in_flag_r <= 1'b0;
        else if (sync_edge)
            sync_in_flag_r <= 1'b1;
        else if (clear_sync)
            sync_in_flag_r <= 1'b0;
    end

    // ****************************************************************
    // Interrupt gating
    // ****************************************************************

    // event gate for all four sources
    // Flags other than the sync flag still record events while their enable is off
    assign irq_event = (fifo_overflow_evt && overflow_irq_enable)
        || (drive_ready_evt && drive_ready_irq_enable)
        || (sample_strobe && sample_ready_irq_enable)
        || sync_edge;

    // pending while any enabled flag stands
    assign irq_pending = (overflow_flag_r && overflow_irq_enable)
        || (drive_ready_flag_r && drive_ready_irq_enable)
        || (sample_ready_flag_r && sample_ready_irq_enable)
        || (sync_in_flag_r && sync_in_irq_enable);

    // ****************************************************************
    // Pulse timer
    // ****************************************************************

    // fixed width pulse; a new event restarts the width
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            pulse_state_r <= PIN_IDLE;
            pulse_cnt_r <= 13'h0000;
        end
        else
        begin
            case (pulse_state_r)
                PIN_IDLE:
                begin
                    if (irq_event)
                    begin
                        pulse_state_r <= PIN_PULSE;
                        pulse_cnt_r <= PULSE_LAST;
                    end
                end
                PIN_PULSE:
                begin
                    if (irq_event)
                        pulse_cnt_r <= PULSE_LAST;
                    else if (pulse_cnt_r == 13'h0000)
                        pulse_state_r <= PIN_IDLE;
                    else
                        pulse_cnt_r <= pulse_cnt_r - 13'h0001;
                end
                default:
                begin
                    pulse_state_r <= PIN_IDLE;
                    pulse_cnt_r <= 13'h0000;
                end
            endcase
        end
    end

    assign irq_active = pin_latched ? irq_pending : (pulse_state_r == PIN_PULSE);

    // ****************************************************************
    // Interrupt pin drive
    // ****************************************************************

    // Registered so the pin never glitches on decode
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            irq_pin_o <= 1'b0;
            irq_pin_oe <= 1'b1;
        end
        else if (pin_open_drain)
        begin
            irq_pin_o <= 1'b0;
            irq_pin_oe <= !(irq_active ^ pin_active_low);
        end
        else
        begin
            irq_pin_o <= irq_active ^ pin_active_low;
            irq_pin_oe <= 1'b1;
        end
    end

    // ****************************************************************
    // Sample capture
    // ****************************************************************

    rate_scale u_scale_x
    (
        .raw_rate(raw_rate_x),
        .range_sel(range_t'(range_select)),
        .rate_word(rate_x_scaled)
    );

    rate_scale u_scale_y
    (
        .raw_rate(raw_rate_y),
        .range_sel(range_t'(range_select)),
        .rate_word(rate_y_scaled)
    );

    rate_scale u_scale_z
    (
        .raw_rate(raw_rate_z),
        .range_sel(range_t'(range_select)),
        .rate_word(rate_z_scaled)
    );

    // All four words change together, so one sample is coherent
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            temp_word_r <= 16'h0000;
            rate_x_word_r <= 16'h0000;
            rate_y_word_r <= 16'h0000;
            rate_z_word_r <= 16'h0000;
        end
        else if (sample_strobe)
        begin
            temp_word_r <= temp_sample;
            rate_x_word_r <= rate_x_scaled;
            rate_y_word_r <= rate_y_scaled;
            rate_z_word_r <= rate_z_scaled;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************

    // Unmapped and reserved bits read as zero
    always_comb
    begin
        read_mux = 8'h00;
        case (reg_addr)
            `ADDR_SYNC_FLAGS:
                read_mux[`SYNC_FLAG_BIT] = sync_in_flag_r;
            `ADDR_PIN_CONFIG:
                read_mux = pin_config_r;
            `ADDR_IRQ_ENABLE:
                read_mux = irq_enable_r;
            `ADDR_IRQ_FLAGS:
            begin
                read_mux[`OVERFLOW_BIT] = overflow_flag_r;
                read_mux[`DRIVE_READY_BIT] = drive_ready_flag_r;
                read_mux[`SAMPLE_READY_BIT] = sample_ready_flag_r;
            end
            `ADDR_TEMP_HIGH:
                read_mux = temp_word_r[15:8];
            `ADDR_TEMP_LOW:
                read_mux = temp_word_r[7:0];
            `ADDR_RATE_X_HIGH:
                read_mux = rate_x_word_r[15:8];
            `ADDR_RATE_X_LOW:
                read_mux = rate_x_word_r[7:0];
            `ADDR_RATE_Y_HIGH:
                read_mux = rate_y_word_r[15:8];
            `ADDR_RATE_Y_LOW:
                read_mux = rate_y_word_r[7:0];
            `ADDR_RATE_Z_HIGH:
                read_mux = rate_z_word_r[15:8];
            `ADDR_RATE_Z_LOW:
                read_mux = rate_z_word_r[7:0];
            default:
                read_mux = 8'h00;
        endcase
    end

    // Data is captured before the same edge clears the flags
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            reg_rdata <= 8'h00;
        else if (reg_rd_en)
            reg_rdata <= read_mux;
    end

endmodule : sensor_irq_and_output_regs

// File: tb/host_pin_model.sv
// ****************************************
// Host side of the interrupt pin
// ****************************************
module host_pin_model
(
    // Pin drive from the device
    input wire logic irq_pin_o,
    input wire logic irq_pin_oe,
    // Level the host sees
    output logic irq_wire
);
    timeunit 1ns;
    timeprecision 1ps;

    // board pull-up
    // Released pin floats to the pull-up level, never the last value
    assign irq_wire = irq_pin_oe ? irq_pin_o : 1'b1;
endmodule : host_pin_model

// File: tb/sensor_irq_chk.sv
// ****************************************
// Interrupt and result register checker
// ****************************************
module sensor_irq_chk
#(
    parameter int unsigned PULSE_CYCLES = 8
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Events and pins
    input wire logic fifo_overflow_evt,
    input wire logic drive_ready_evt,
    input wire logic sample_strobe,
    input wire logic [15:0] temp_sample,
    input wire logic frame_sync_in,
    input wire logic irq_pin_o,
    input wire logic irq_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cfg_r;
    logic [7:0] cfg_d_r;
    logic [7:0] en_r;
    logic [15:0] tcap_r;
    logic [15:0] age_r;
    logic fs_r;
    logic act;
    logic ev;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // Shadows of config, enables and capture; delayed copy matches pin lag
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            cfg_r <= 8'h00;
            cfg_d_r <= 8'h00;
            en_r <= 8'h00;
            tcap_r <= 16'h0000;
        end
        else
        begin
            cfg_d_r <= cfg_r;
            if (reg_wr_en && reg_addr == 8'h37)
                cfg_r <= reg_wdata & 8'hFC;
            if (reg_wr_en && reg_addr == 8'h38)
                en_r <= reg_wdata & 8'h15;
            if (sample_strobe)
                tcap_r <= temp_sample;
        end
    end

    // Cycles since any event; counts all events, so it is conservative
    assign ev = fifo_overflow_evt | drive_ready_evt | sample_strobe | (fs_r != frame_sync_in);
    always_ff @(posedge sys_clk)
    begin
        fs_r <= frame_sync_in;
        if (!reset_n || ev)
            age_r <= 16'h0000;
        else if (age_r != 16'hFFFF)
            age_r <= age_r + 16'h0001;
    end

    // Pin asserted, with the pull-up standing in for a released pin
    assign act = (irq_pin_oe ? irq_pin_o : 1'b1) ^ cfg_d_r[7];

    temp_word_a: assert property (reg_rd_en && (reg_addr == 8'h41 || reg_addr == 8'h42) && !sample_strobe |=> reg_rdata == ($past(reg_addr[0]) ? $past(tcap_r[15:8]) : $past(tcap_r[7:0])))
        else $error("temperature byte differs from captured sample");
    flags_clear_a: assert property ((reg_rd_en && reg_addr == 8'h3A && !ev) ##1 !ev [*2] ##1 (reg_rd_en && reg_addr == 8'h3A && !ev) |=> reg_rdata == 8'h00)
        else $error("flags survived a read");
    push_pull_a: assert property (!cfg_r[6] && !cfg_d_r[6] |-> irq_pin_oe)
        else $error("push-pull pin released");
    open_drain_a: assert property (cfg_r[6] && cfg_d_r[6] |-> !(irq_pin_oe && irq_pin_o))
        else $error("open-drain pin driven high");
    irq_rise_a: assert property ((sample_strobe && en_r[0] && !reg_wr_en) ##1 !reg_wr_en |=> act)
        else $error("enabled data ready did not assert pin");
    pulse_end_a: assert property (!cfg_d_r[5] && cfg_d_r == cfg_r && age_r > 16'(PULSE_CYCLES + 4) |-> !act)
        else $error("pulse outlasted its width");
    latch_hold_a: assert property (cfg_d_r[5] && cfg_d_r == cfg_r && act && !reg_rd_en && !reg_wr_en && !$past(reg_rd_en) && !$past(reg_wr_en) |=> act)
        else $error("latched pin dropped without a clear");
    disabled_quiet_a: assert property (cfg_d_r[5] && en_r == 8'h00 && $past(en_r) == 8'h00 && !cfg_r[2] && !$past(cfg_r[2]) && cfg_d_r == cfg_r |-> !act)
        else $error("pin asserted with all sources disabled");
endmodule : sensor_irq_chk

bind sensor_irq_and_output_regs sensor_irq_chk #(.PULSE_CYCLES(PULSE_CYCLES)) chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fifo_overflow_evt(fifo_overflow_evt), .drive_ready_evt(drive_ready_evt),
    .sample_strobe(sample_strobe), .temp_sample(temp_sample), .frame_sync_in(frame_sync_in),
    .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe));

// File: tb/tb.sv
// ****************************************
// Register and interrupt pin bench
// ****************************************
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PULSE = 8;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [2:0] evt = 3'b000; // Overflow, drive ready, sample
    logic [15:0] temp_sample = 16'h0000;
    logic signed [18:0] raw_x = 19'sd0;
    logic signed [18:0] raw_y = 19'sd0;
    logic signed [18:0] raw_z = 19'sd0;
    logic [1:0] range_select = 2'b00;
    logic frame_sync_in = 1'b0;
    logic irq_pin_o;
    logic irq_pin_oe;
    logic irq_wire;
    logic [7:0] rd_v;
    logic [15:0] w [4];
    int n_errors = 0;
    int num_checks = 0;

    sensor_irq_and_output_regs #(.PULSE_CYCLES(PULSE)) dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .fifo_overflow_evt(evt[2]), .drive_ready_evt(evt[1]), .sample_strobe(evt[0]),
        .temp_sample(temp_sample), .raw_rate_x(raw_x), .raw_rate_y(raw_y), .raw_rate_z(raw_z),
        .range_select(range_select), .frame_sync_in(frame_sync_in), .irq_pin_o(irq_pin_o),
        .irq_pin_oe(irq_pin_oe));
    host_pin_model pin_model (.irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe),
        .irq_wire(irq_wire));

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    // Saturating word, independent of the design's scaler
    function automatic logic [15:0] sat16(input int v);
        if (v > 32767)
            return 16'h7FFF;
        if (v < -32768)
            return 16'h8000;
        return 16'(v);
    endfunction : sat16

    // Bus cycles: strobe for one taken edge, read data sampled just after it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
    endtask : wr
    task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        #1 rd_v = reg_rdata;
        num_checks++;
        if (rd_v !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, rd_v);
        end
    endtask : rc
    task automatic pn(input logic e, input int n);
        repeat (n) @(posedge sys_clk);
        #1 num_checks++;
        if (irq_wire !== e)
        begin
            n_errors++;
            $display("wrong value irq pin expected %b seen %b", e, irq_wire);
        end
    endtask : pn
    task automatic fire(input logic [2:0] k);
        @(posedge sys_clk);
        evt <= k;
        @(posedge sys_clk);
        evt <= 3'b000;
    endtask : fire
    // Frame sync change under a config, then flag and pin compared
    task automatic sy(input logic [7:0] c, input logic f, input logic [7:0] e);
        wr(8'h37, c);
        @(posedge sys_clk);
        frame_sync_in <= f;
        repeat (6) @(posedge sys_clk);
        pn(e[7], 0);
        rc("sync flag", 8'h36, e);
    endtask : sy
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // Hang guard, far beyond the few hundred cycles of the tests
    initial
    begin
        #200000;
        n_errors++;
        conclude();
    end

    initial
    begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            rc("result", 8'(8'h41 + i), 8'h00);
        rc("pin config", 8'h37, 8'h00);
        wr(8'h37, 8'hFA);
        rc("pin config", 8'h37, 8'hF8);
        wr(8'h38, 8'hFF);
        rc("enable", 8'h38, 8'h15);
        wr(8'h41, 8'hAA);
        rc("temp high", 8'h41, 8'h00);
        rc("unmapped", 8'h00, 8'h00);
        wr(8'h37, 8'h00);
        wr(8'h38, 8'h00);
        $display("test registers finished");
        // scaled rate words over every range
        for (int r = 0; r < 4; r++)
        begin
            @(posedge sys_clk);
            range_select <= 2'(r);
            temp_sample <= 16'h1230 + 16'(r);
            raw_x <= 19'sd13100; // 100 dps at 131 LSB/dps
            raw_y <= -19'sd13100;
            raw_z <= 19'sd39300;
            w[0] = 16'h1230 + 16'(r);
            w[1] = sat16(13100 >>> r);
            w[2] = sat16(-13100 >>> r);
            w[3] = sat16(39300 >>> r);
            fire(3'b001);
            for (int i = 0; i < 8; i++)
                rc("result", 8'(8'h41 + i), i[0] ? w[i / 2][7:0] : w[i / 2][15:8]);
        end
        $display("test rates finished");
        // polarity and drive type in pulse mode
        wr(8'h38, 8'h01);
        for (int m = 0; m < 4; m++)
        begin
            wr(8'h37, {m[1:0], 6'h00});
            fire(3'b001);
            pn(!m[1], 1);
            pn(!m[1], PULSE - 1);
            pn(m[1], 1);
            rc("flags", 8'h3A, 8'h01);
        end
        $display("test pulse finished");
        // gating, flags and latching per source
        wr(8'h37, 8'h20);
        wr(8'h38, 8'h00);
        fire(3'b111);
        pn(1'b0, 3);
        rc("flags", 8'h3A, 8'h15);
        for (int b = 0; b < 3; b++)
        begin
            wr(8'h38, 8'h01 << (2 * b));
            fire(3'b001 << b);
            pn(1'b1, 10);
            rc("flags", 8'h3A, 8'h01 << (2 * b));
            pn(1'b0, 1);
            rc("flags", 8'h3A, 8'h00);
        end
        $display("test latch finished");
        // clearing by any read or by the flag read only
        wr(8'h38, 8'h01);
        wr(8'h37, 8'h30);
        fire(3'b001);
        rc("temp high", 8'h41, 8'h12);
        pn(1'b0, 1);
        rc("flags", 8'h3A, 8'h00);
        wr(8'h37, 8'h20);
        fire(3'b001);
        rc("temp high", 8'h41, 8'h12);
        pn(1'b1, 1);
        rc("flags", 8'h3A, 8'h01);
        $display("test read clear finished");
        wr(8'h38, 8'h00);
        sy(8'h24, 1'b1, 8'h80);
        sy(8'h2C, 1'b0, 8'h80);
        sy(8'h2C, 1'b1, 8'h00);
        sy(8'h20, 1'b0, 8'h00);
        sy(8'h20, 1'b1, 8'h00);
        $display("test frame sync finished");
        conclude();
    end
endmodule : tb
